// ---- inc/pio_pkg.sv ----
package pio_pkg;
    // Geometry
    localparam int NUM_PORTS = 3;              // Ports 0..2
    localparam int PORT_W    = 8;              // Pins per port
    localparam int PIN_W     = NUM_PORTS * PORT_W;
    localparam int DIG_ONLY_PIN = 2 * PORT_W + 4;  // Pin 2.4 flat index

    // Register addresses on the core register bus
    localparam logic [7:0] ADDR_P0_DATA  = 8'h80;
    localparam logic [7:0] ADDR_P1_DATA  = 8'h90;
    localparam logic [7:0] ADDR_P2_DATA  = 8'hA0;
    localparam logic [7:0] ADDR_P0_MDOUT = 8'hA4;
    localparam logic [7:0] ADDR_P1_MDOUT = 8'hA5;
    localparam logic [7:0] ADDR_P2_MDOUT = 8'hA6;
    localparam logic [7:0] ADDR_P0_SKIP  = 8'hD4;
    localparam logic [7:0] ADDR_P1_SKIP  = 8'hD5;
    localparam logic [7:0] ADDR_P2_SKIP  = 8'hD6;
    localparam logic [7:0] ADDR_P1_MAT   = 8'hED;
    localparam logic [7:0] ADDR_P1_MASK  = 8'hEE;
    localparam logic [7:0] ADDR_P0_MDIN  = 8'hF1;
    localparam logic [7:0] ADDR_P1_MDIN  = 8'hF2;
    localparam logic [7:0] ADDR_P2_MDIN  = 8'hF3;
    localparam logic [7:0] ADDR_P0_MAT   = 8'hFD;
    localparam logic [7:0] ADDR_P0_MASK  = 8'hFE;

    // Reset values
    localparam logic [7:0] RST_DATA  = 8'hFF;
    localparam logic [7:0] RST_MAT   = 8'hFF;
    localparam logic [7:0] RST_MASK  = 8'h00;
    localparam logic [7:0] RST_MDIN  = 8'hFF;
    localparam logic [7:0] RST_MDOUT = 8'h00;
    localparam logic [7:0] RST_SKIP  = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Register selected by an address
    typedef enum logic [3:0] {
        SEL_NONE, SEL_DATA, SEL_MDIN, SEL_MDOUT, SEL_SKIP,
        SEL_MAT0, SEL_MASK0, SEL_MAT1, SEL_MASK1
    } pio_sel_t;

    typedef struct packed {
        pio_sel_t    sel;
        logic [1:0]  port;
    } pio_dec_t;

    // Byte address to register and port
    function automatic pio_dec_t pio_decode(input logic [7:0] a);
        pio_dec_t d;
        d = '{SEL_NONE, 2'h0};
        case (a)
            ADDR_P0_DATA:  d = '{SEL_DATA, 2'h0};
            ADDR_P1_DATA:  d = '{SEL_DATA, 2'h1};
            ADDR_P2_DATA:  d = '{SEL_DATA, 2'h2};
            ADDR_P0_MDIN:  d = '{SEL_MDIN, 2'h0};
            ADDR_P1_MDIN:  d = '{SEL_MDIN, 2'h1};
            ADDR_P2_MDIN:  d = '{SEL_MDIN, 2'h2};
            ADDR_P0_MDOUT: d = '{SEL_MDOUT, 2'h0};
            ADDR_P1_MDOUT: d = '{SEL_MDOUT, 2'h1};
            ADDR_P2_MDOUT: d = '{SEL_MDOUT, 2'h2};
            ADDR_P0_SKIP:  d = '{SEL_SKIP, 2'h0};
            ADDR_P1_SKIP:  d = '{SEL_SKIP, 2'h1};
            ADDR_P2_SKIP:  d = '{SEL_SKIP, 2'h2};
            ADDR_P0_MAT:   d = '{SEL_MAT0, 2'h0};
            ADDR_P0_MASK:  d = '{SEL_MASK0, 2'h0};
            ADDR_P1_MAT:   d = '{SEL_MAT1, 2'h1};
            ADDR_P1_MASK:  d = '{SEL_MASK1, 2'h1};
            default:       d = '{SEL_NONE, 2'h0};
        endcase
        return d;
    endfunction
endpackage

// ---- inc/pio_match_if.sv ----
`timescale 1ns/100ps
// Pins and match settings handed to the mismatch comparator
interface pio_match_if;
    logic [7:0] pin0;       // Synchronised port 0 levels
    logic [7:0] pin1;       // Synchronised port 1 levels
    logic [7:0] mat0;       // Port 0 expected levels
    logic [7:0] mask0;      // Port 0 compare enables
    logic [7:0] mat1;       // Port 1 expected levels
    logic [7:0] mask1;      // Port 1 compare enables
    logic       mismatch;   // Registered mismatch level

    modport src (output pin0, pin1, mat0, mask0, mat1, mask1, input mismatch);
    modport cmp (input pin0, pin1, mat0, mask0, mat1, mask1, output mismatch);
endinterface

// ---- rtl/pio_sync.sv ----
`timescale 1ns/100ps
// Two-stage synchroniser for pin levels
module pio_sync #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pio_sync: WIDTH must be positive");
    end

    logic [WIDTH-1:0] meta_reg;   // First stage, read by second stage only

    // Pins idle high through their weak pull-ups
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_reg <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // pio_sync

// ---- rtl/pio_match.sv ----
`timescale 1ns/100ps
// Port 0 / port 1 mismatch comparator
module pio_match (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    pio_match_if.cmp  mif
);
    import pio_pkg::*;

    // Compare only masked pins; mask 0 drops the pin
    function automatic logic differs(input logic [7:0] p, m, k);
        return (p & k) != (m & k);
    endfunction

    // Registered so the flag is glitch free
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            mif.mismatch <= 1'b0;
        else
            mif.mismatch <= differs(mif.pin0, mif.mat0, mif.mask0) |
                            differs(mif.pin1, mif.mat1, mif.mask1);
    end
endmodule // pio_match

// ---- rtl/pio_port.sv ----
`timescale 1ns/100ps
// Port I/O data latches, pin modes, skip selection and match
module pio_port (
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    // Core register bus
    input  wire logic [7:0]             sfr_addr_in,
    input  wire logic                   sfr_wr_in,
    input  wire logic                   sfr_rd_in,
    input  wire logic                   sfr_bit_in,
    input  wire logic                   sfr_rmw_in,
    input  wire logic [7:0]             sfr_wdata_in,
    output logic      [7:0]             sfr_rdata_out,
    // Crossbar side
    input  wire logic [pio_pkg::PIN_W-1:0] xbar_sel_in,
    input  wire logic [pio_pkg::PIN_W-1:0] xbar_data_in,
    input  wire logic [pio_pkg::PIN_W-1:0] xbar_smbus_in,
    output logic      [pio_pkg::PIN_W-1:0] skip_out,
    // Pins
    input  wire logic [pio_pkg::PIN_W-1:0] pad_in,
    output logic      [pio_pkg::PIN_W-1:0] pad_out,
    output logic      [pio_pkg::PIN_W-1:0] pad_oe_b_out,
    output logic      [pio_pkg::PIN_W-1:0] pullup_en_out,
    output logic                           mismatch_out
);
    import pio_pkg::*;

    // Bus geometry is fixed by the byte-wide register bus
    if (PORT_W != 8 || NUM_PORTS != 3)
    begin : g_bad_geom
        $error("pio_port: only three 8-bit ports are supported");
    end

    logic [NUM_PORTS-1:0][7:0] data_reg;    // Output latches
    logic [NUM_PORTS-1:0][7:0] mdin_reg;    // 1 digital, 0 analog
    logic [NUM_PORTS-1:0][7:0] mdout_reg;   // 1 push-pull, 0 open-drain
    logic [NUM_PORTS-1:0][7:0] skip_reg;    // 1 crossbar passes over
    logic [7:0]                mat0_reg;    // Port 0 expected levels
    logic [7:0]                mask0_reg;   // Port 0 compare enables
    logic [7:0]                mat1_reg;    // Port 1 expected levels
    logic [7:0]                mask1_reg;   // Port 1 compare enables
    logic [PIN_W-1:0]          pin_sync;    // Synchronised pin levels
    logic [PIN_W-1:0]          digital;     // Effective digital mode
    logic [PIN_W-1:0]          pin_val;     // Level seen by a plain read
    logic [PIN_W-1:0]          drv_val;     // Value the pin should carry
    logic [PIN_W-1:0]          open_drain;  // Effective open-drain mode
    logic [PIN_W-1:0]          drive;       // Pin actively driven
    logic [7:0]                byte_addr;   // Register address of access
    logic [2:0]                bit_idx;     // Bit within addressed byte
    pio_dec_t                  dec;         // Decoded access target
    logic [7:0]                data_src;    // Latch or pins for a data read
    logic [7:0]                rdata_next;  // Read answer

    pio_match_if mif ();

    // Pin levels cross in from outside
    pio_sync #(
        .WIDTH    (PIN_W)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    // Bit accesses address byte {a[7:3],000} and bit a[2:0]
    always_comb
    begin
        byte_addr = sfr_bit_in ? {sfr_addr_in[7:3], 3'h0} : sfr_addr_in;
        bit_idx   = sfr_addr_in[2:0];
        dec       = pio_decode(byte_addr);
        // Only data registers are bit addressable
        if (sfr_bit_in && dec.sel != SEL_DATA)
            dec = '{SEL_NONE, 2'h0};
    end

    // Effective pin modes; pin 2.4 cannot go analog
    always_comb
    begin
        digital               = mdin_reg;
        digital[DIG_ONLY_PIN] = 1'b1;
        pin_val               = pin_sync & digital;
        drv_val               = (xbar_sel_in & xbar_data_in) |
                                (~xbar_sel_in & data_reg);
        open_drain            = ~mdout_reg | xbar_smbus_in;
        // Open-drain pulls low only; analog never drives
        drive                 = digital & (~open_drain | ~drv_val);
    end

    // Output latches, byte or single bit
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            data_reg <= {NUM_PORTS{RST_DATA}};
        else if (sfr_wr_in && dec.sel == SEL_DATA)
        begin
            if (sfr_bit_in)
                data_reg[dec.port][bit_idx] <= sfr_wdata_in[0];
            else
                data_reg[dec.port] <= sfr_wdata_in;
        end
    end

    // Mode and skip selections, written by software only
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mdin_reg  <= {NUM_PORTS{RST_MDIN}};
            mdout_reg <= {NUM_PORTS{RST_MDOUT}};
            skip_reg  <= {NUM_PORTS{RST_SKIP}};
        end
        else if (sfr_wr_in)
        begin
            case (dec.sel)
                SEL_MDIN:  mdin_reg[dec.port]  <= sfr_wdata_in;
                SEL_MDOUT: mdout_reg[dec.port] <= sfr_wdata_in;
                SEL_SKIP:  skip_reg[dec.port]  <= sfr_wdata_in;
                default:   ;                                        // Not a mode register
            endcase
        end
    end

    // Match and mask settings
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mat0_reg  <= RST_MAT;
            mask0_reg <= RST_MASK;
            mat1_reg  <= RST_MAT;
            mask1_reg <= RST_MASK;
        end
        else if (sfr_wr_in)
        begin
            case (dec.sel)
                SEL_MAT0:  mat0_reg  <= sfr_wdata_in;
                SEL_MASK0: mask0_reg <= sfr_wdata_in;
                SEL_MAT1:  mat1_reg  <= sfr_wdata_in;
                SEL_MASK1: mask1_reg <= sfr_wdata_in;
                default:   ;                                        // Not a match register
            endcase
        end
    end

    // Read answer; read-modify-write sees the latch
    always_comb
    begin
        data_src   = sfr_rmw_in ? data_reg[dec.port]
                                : pin_val[dec.port*8 +: 8];
        rdata_next = RD_UNMAPPED;
        case (dec.sel)
            SEL_DATA:
            begin
                if (sfr_bit_in)
                    rdata_next = {7'h00, data_src[bit_idx]};
                else
                    rdata_next = data_src;
            end
            SEL_MDIN:
            begin
                rdata_next = mdin_reg[dec.port];
                if (dec.port == 2'h2)
                    rdata_next[DIG_ONLY_PIN - 2*PORT_W] = 1'b1;
            end
            SEL_MDOUT: rdata_next = mdout_reg[dec.port];
            SEL_SKIP:  rdata_next = skip_reg[dec.port];
            SEL_MAT0:  rdata_next = mat0_reg;
            SEL_MASK0: rdata_next = mask0_reg;
            SEL_MAT1:  rdata_next = mat1_reg;
            SEL_MASK1: rdata_next = mask1_reg;
            default:   rdata_next = RD_UNMAPPED;                    // Unmapped reads zero
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            sfr_rdata_out <= 8'h00;
        else if (sfr_rd_in)
            sfr_rdata_out <= rdata_next;
    end

    // Pad drivers; one cycle late, which keeps outputs glitch free
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pad_out       <= '1;
            pad_oe_b_out  <= '1;
            pullup_en_out <= '1;
            skip_out      <= '0;
        end
        else
        begin
            pad_out       <= drv_val;
            pad_oe_b_out  <= ~drive;
            pullup_en_out <= digital;
            skip_out      <= skip_reg;
        end
    end

    // Comparator feed
    assign mif.pin0  = pin_sync[7:0];
    assign mif.pin1  = pin_sync[15:8];
    assign mif.mat0  = mat0_reg;
    assign mif.mask0 = mask0_reg;
    assign mif.mat1  = mat1_reg;
    assign mif.mask1 = mask1_reg;
    assign mismatch_out = mif.mismatch;

    pio_match u_match (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .mif      (mif.cmp)
    );

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // Reset aborts any check in flight, so no check sees reset values

    mismatch_flag_a: assert property (
        ##1 mismatch_out == $past(((pin_sync[7:0] & mask0_reg) != (mat0_reg & mask0_reg))
            | ((pin_sync[15:8] & mask1_reg) != (mat1_reg & mask1_reg))))
        else $error("mismatch flag disagrees with masked pins");

    port1_compare_a: assert property (
        (mask0_reg == 8'h00)
        |=> mismatch_out == $past(|((pin_sync[15:8] ^ mat1_reg) & mask1_reg)))
        else $error("port 1 compare disagrees with match bits");

    bit_write_a: assert property (
        (sfr_wr_in && sfr_bit_in && dec.sel == SEL_DATA)
        |=> data_reg[$past(dec.port)][$past(bit_idx)] == $past(sfr_wdata_in[0]))
        else $error("bit write did not reach latch");

    latch_hold_a: assert property (
        !(sfr_wr_in && dec.sel == SEL_DATA) |=> $stable(data_reg))
        else $error("latch changed without a write");

    pin_read_a: assert property (
        (sfr_rd_in && !sfr_rmw_in && !sfr_bit_in && dec.sel == SEL_DATA)
        |=> sfr_rdata_out == $past(pin_val[dec.port*8 +: 8]))
        else $error("plain read did not return pins");

    rmw_read_a: assert property (
        (sfr_rd_in && sfr_rmw_in && !sfr_bit_in && dec.sel == SEL_DATA)
        |=> sfr_rdata_out == $past(data_reg[dec.port]))
        else $error("rmw read did not return latch");

    bit_rmw_a: assert property (
        (sfr_rd_in && sfr_rmw_in && sfr_bit_in && dec.sel == SEL_DATA)
        |=> sfr_rdata_out == {7'h00, $past(data_reg[dec.port][bit_idx])})
        else $error("bit rmw read did not return latch bit");

    skip_follow_a: assert property (
        ##1 skip_out == $past(skip_reg))
        else $error("skip output lags wrongly");

    digital_only_a: assert property (
        ##1 pullup_en_out[DIG_ONLY_PIN])
        else $error("pin 2.4 left digital mode");

    analog_off_a: assert property (
        ##1 ((pad_oe_b_out & ~pullup_en_out) == ~pullup_en_out))
        else $error("analog pin driven");

    smbus_od_a: assert property (
        ##1 ($past(xbar_smbus_in & drv_val) & ~pad_oe_b_out) == '0)
        else $error("serial bus pin drove high");

    byte_write_a: assert property (
        (sfr_wr_in && !sfr_bit_in && dec.sel == SEL_DATA)
        |=> data_reg[$past(dec.port)] == $past(sfr_wdata_in))
        else $error("byte write did not reach latch");

    mdin_write_a: assert property (
        (sfr_wr_in && dec.sel == SEL_MDIN)
        |=> mdin_reg[$past(dec.port)] == $past(sfr_wdata_in))
        else $error("input mode write did not land");

    mdout_write_a: assert property (
        (sfr_wr_in && dec.sel == SEL_MDOUT)
        |=> mdout_reg[$past(dec.port)] == $past(sfr_wdata_in))
        else $error("output mode write did not land");

    skip_write_a: assert property (
        (sfr_wr_in && dec.sel == SEL_SKIP)
        |=> skip_reg[$past(dec.port)] == $past(sfr_wdata_in))
        else $error("skip write did not land");

    pp_drive_a: assert property (
        ##1 ($past(digital & mdout_reg & ~xbar_smbus_in) & pad_oe_b_out) == '0)
        else $error("push-pull pin not driven");

    unmapped_read_a: assert property (
        (sfr_rd_in && dec.sel == SEL_NONE)
        |=> sfr_rdata_out == RD_UNMAPPED)
        else $error("unmapped read returned data");

    cover_mismatch_c: cover property (!mismatch_out ##1 mismatch_out);
    cover_bit_write_c: cover property (sfr_wr_in && sfr_bit_in && dec.sel == SEL_DATA);
    cover_rmw_read_c: cover property (sfr_rd_in && sfr_rmw_in && dec.sel == SEL_DATA);
    cover_od_low_c: cover property (|(open_drain & drive));
    cover_analog_c: cover property (|(~digital));
endmodule // pio_port

// ---- test/pio_pin_model.sv ----
`timescale 1ns/100ps
// Far side of the pins: weak pull-ups, outside pull-downs, floating analog lines
module pio_pin_model (
    input  wire logic                      clk_in,
    input  wire logic [pio_pkg::PIN_W-1:0] pad_out_in,
    input  wire logic [pio_pkg::PIN_W-1:0] pad_oe_b_in,
    input  wire logic [pio_pkg::PIN_W-1:0] pullup_en_in,
    input  wire logic [pio_pkg::PIN_W-1:0] ext_low_in,
    output logic      [pio_pkg::PIN_W-1:0] pin_out
);
    import pio_pkg::*;

    logic [PIN_W-1:0] float_q = '0;    // Undriven, unpulled lines wander

    // Toggle every cycle so a released line never shows a stale value
    always_ff @(posedge clk_in)
    begin
        float_q <= ~float_q;
    end

    // Driven pins show the driver, released ones the pull-up or a wandering level
    // Outside open-drain parties may pull any pin low
    assign pin_out = ((~pad_oe_b_in & pad_out_in)
                   | (pad_oe_b_in & (pullup_en_in | float_q))) & ~ext_low_in;
endmodule // pio_pin_model

// ---- test/tb.sv ----
`timescale 1ns/100ps
// Self-checking bench for the port block
module tb;
    import pio_pkg::*;

    logic             clk_in = 1'b0;       // 10 MHz system clock
    logic             rst_b_in = 1'b0;     // Asynchronous reset
    logic [7:0]       sfr_addr_in = '0;    // Register bus
    logic             sfr_wr_in = 1'b0;
    logic             sfr_rd_in = 1'b0;
    logic             sfr_bit_in = 1'b0;
    logic             sfr_rmw_in = 1'b0;
    logic [7:0]       sfr_wdata_in = '0;
    logic [7:0]       sfr_rdata_out;
    logic [PIN_W-1:0] xbar_sel_in = '0;    // Crossbar side
    logic [PIN_W-1:0] xbar_data_in = '0;
    logic [PIN_W-1:0] xbar_smbus_in = '0;
    logic [PIN_W-1:0] skip_out;
    logic [PIN_W-1:0] pad_in;              // Resolved pin levels
    logic [PIN_W-1:0] pad_out;
    logic [PIN_W-1:0] pad_oe_b_out;
    logic [PIN_W-1:0] pullup_en_out;
    logic             mismatch_out;
    logic [PIN_W-1:0] ext_low = '0;        // Outside pull-downs
    int               bad_count = 0;
    int               n_tests = 0;
    int               cyc = 0;
    logic [7:0]       rd;

    always #50 clk_in = ~clk_in;

    pio_port pio_port_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_bit_in(sfr_bit_in),
        .sfr_rmw_in(sfr_rmw_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .xbar_sel_in(xbar_sel_in), .xbar_data_in(xbar_data_in),
        .xbar_smbus_in(xbar_smbus_in), .skip_out(skip_out), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_b_out(pad_oe_b_out), .pullup_en_out(pullup_en_out),
        .mismatch_out(mismatch_out));

    pio_pin_model pio_pin_model_i (.clk_in(clk_in), .pad_out_in(pad_out),
        .pad_oe_b_in(pad_oe_b_out), .pullup_en_in(pullup_en_out),
        .ext_low_in(ext_low), .pin_out(pad_in));

    // Hang guard, well above the roughly 240 cycles the run needs
    always @(posedge clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One strobe cycle; strobes always drop for a cycle between accesses
    task automatic acc(input logic [7:0] a, input logic w, input logic b, input logic m,
                       input logic [7:0] d);
        @(posedge clk_in);
        #1;
        sfr_addr_in = a;
        sfr_wr_in = w;
        sfr_rd_in = ~w;
        sfr_bit_in = b;
        sfr_rmw_in = m;
        sfr_wdata_in = d;
        @(posedge clk_in);
        #1;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 1'b1, 1'b0, 1'b0, d);
    endtask

    // Answer holds until the next read, so one spare edge costs nothing
    task automatic rdc(input string n, input logic [7:0] a, input logic b, input logic m,
                       input logic [7:0] e);
        acc(a, 1'b0, b, m, 8'h00);
        @(posedge clk_in);
        #1;
        check(n, {16'h0000, sfr_rdata_out}, {16'h0000, e});
    endtask

    // Long enough for register, pad and two-flop synchroniser to settle
    task automatic settle();
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic t_reset();
        logic [7:0] adr [11] = '{8'h80, 8'h90, 8'hA0, 8'hF1, 8'hA4, 8'hD4, 8'hED, 8'hEE,
                                 8'hFD, 8'hFE, 8'h33};
        logic [7:0] exp [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00,
                                 8'hFF, 8'h00, 8'h00};
        for (int i = 0; i < 11; i++)
            rdc("reset_reg", adr[i], 1'b0, 1'b0, exp[i]);
        check("skip_rst", skip_out, 24'h000000);
        check("oe_rst", pad_oe_b_out, 24'hFFFFFF);
        check("pullup_rst", pullup_en_out, 24'hFFFFFF);
        check("mm_rst", {23'h0, mismatch_out}, 24'h0);
    endtask

    // Latch versus pin, byte and bit, plain and read-modify-write
    task automatic t_latch();
        wr(8'h80, 8'h5A);
        ext_low[1] = 1'b1;
        settle();
        check("p0_pad", pad_out[7:0], 24'h5A);
        check("p0_oe", pad_oe_b_out[7:0], 24'h5A);
        rdc("p0_pin", 8'h80, 1'b0, 1'b0, 8'h58);
        rdc("p0_rmw", 8'h80, 1'b0, 1'b1, 8'h5A);
        acc(8'h80, 1'b1, 1'b1, 1'b0, 8'h01);
        settle();
        check("bit_wr", pad_out[7:0], 24'h5B);
        rdc("bit_pin", 8'h81, 1'b1, 1'b0, 8'h00);
        rdc("bit_rmw", 8'h81, 1'b1, 1'b1, 8'h01);
        rdc("byte_rmw", 8'h80, 1'b0, 1'b1, 8'h5B);
        ext_low[1] = 1'b0;
    endtask

    // Push-pull drive, then analog upper nibble
    task automatic t_modes();
        wr(8'hA4, 8'hFF);
        settle();
        check("pp_oe", pad_oe_b_out[7:0], 24'h00);
        wr(8'hF1, 8'h0F);
        settle();
        check("an_oe", pad_oe_b_out[7:0], 24'hF0);
        check("an_pull", pullup_en_out[7:0], 24'h0F);
        rdc("an_read", 8'h80, 1'b0, 1'b0, 8'h0B);
        wr(8'hF1, 8'hFF);
        wr(8'hA4, 8'h00);
        wr(8'h80, 8'hFF);
    endtask

    // Serial bus pin held open-drain even with push-pull selected
    task automatic t_smbus();
        wr(8'hA4, 8'hFF);
        xbar_sel_in[3] = 1'b1;
        xbar_smbus_in[3] = 1'b1;
        xbar_data_in[3] = 1'b0;
        settle();
        check("sm_low", {pad_oe_b_out[3], pad_out[3]}, 24'h0);
        rdc("xb_pin", 8'h80, 1'b0, 1'b0, 8'hF7);
        rdc("xb_rmw", 8'h80, 1'b0, 1'b1, 8'hFF);
        xbar_data_in[3] = 1'b1;
        settle();
        check("sm_rel", {23'h0, pad_oe_b_out[3]}, 24'h1);
        xbar_sel_in = '0;
        xbar_smbus_in = '0;
        wr(8'hA4, 8'h00);
    endtask

    // Skip bits go straight to the crossbar; pin 2.4 stays digital
    task automatic t_skip();
        wr(8'hD5, 8'h3C);
        wr(8'hD6, 8'h81);
        settle();
        check("skip", skip_out, 24'h813C00);
        rdc("skip_rd", 8'hD5, 1'b0, 1'b0, 8'h3C);
        wr(8'hF3, 8'h00);
        settle();
        check("p24_pull", pullup_en_out[23:16], 24'h10);
        rdc("p24_rd", 8'hF3, 1'b0, 1'b0, 8'h10);
        wr(8'hF3, 8'hFF);
    endtask

    // Masked compare on both ports
    task automatic t_match();
        wr(8'hEE, 8'h00);
        wr(8'hED, 8'h00);
        settle();
        check("mm_masked", {23'h0, mismatch_out}, 24'h0);
        wr(8'hEE, 8'h81);
        wr(8'hED, 8'h81);
        rdc("mat1_rd", 8'hED, 1'b0, 1'b0, 8'h81);
        settle();
        check("mm_eq", {23'h0, mismatch_out}, 24'h0);
        wr(8'hED, 8'h80);
        settle();
        check("mm_hi", {23'h0, mismatch_out}, 24'h1);
        ext_low[8] = 1'b1;
        settle();
        check("mm_lo", {23'h0, mismatch_out}, 24'h0);
        wr(8'hEE, 8'h00);
        wr(8'hFE, 8'h01);
        settle();
        check("mm0_eq", {23'h0, mismatch_out}, 24'h0);
        ext_low[0] = 1'b1;
        settle();
        check("mm0_ne", {23'h0, mismatch_out}, 24'h1);
        ext_low = '0;
    endtask

    // Other ports' latches and modes; bit access to a non-data register is refused
    task automatic t_ports();
        wr(8'hA0, 8'h3C);
        wr(8'hA5, 8'hFF);
        acc(8'h97, 1'b1, 1'b1, 1'b0, 8'h00);
        settle();
        check("p2_pad", pad_out[23:16], 24'h3C);
        check("p1_oe", pad_oe_b_out[15:8], 24'h00);
        rdc("p1_rmw", 8'h90, 1'b0, 1'b1, 8'h7F);
        rdc("p1_pin", 8'h90, 1'b0, 1'b0, 8'h7F);
        acc(8'hF1, 1'b1, 1'b1, 1'b0, 8'h00);
        rdc("nb_rd", 8'hF1, 1'b1, 1'b0, 8'h00);
        rdc("mdin_keep", 8'hF1, 1'b0, 1'b0, 8'hFF);
        wr(8'hA5, 8'h00);
    endtask

    // Reset for 16 cycles, release just after an edge
    initial
    begin
        repeat (16) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        settle();
        t_reset();
        t_latch();
        t_modes();
        t_smbus();
        t_skip();
        t_match();
        t_ports();
        end_sim();
    end
endmodule // tb
